// ==== rtl/router_pkg.sv ====
// constants shared by the channel router device end and its highway controller
// Behaviour
// - highway runs only while highway_enable_n is 0
// - enabled highway: power status from config
// - clock and strobe idle until a slot enabled
// - tap bit clear copies downstream D
// - local bit clear takes upstream D from highway
// - strobe envelope and polarity, default B1 high
// - two-bit fields select B1, B2 sources
// - all ones subscriber; bit 1 clear highway
// - disabled slots leave data undriven
// - echo bit clear makes echo differ
// - controller waits 1.5 ms before local D
// - upstream D ones during takeover wait
// - controller restores echo bit when done
// - default setup passes D straight through
package router_pkg;
    // ==========
    // timing
    localparam int CLOCK_MHZ            = 50;
    localparam int TAKEOVER_WAIT_US     = 1500;
    localparam int TAKEOVER_WAIT_CYCLES = TAKEOVER_WAIT_US * CLOCK_MHZ;
    // ==========
    // device register indexes and reset values
    localparam logic [2:0] REG_STATUS      = 3'h0;
    localparam logic [2:0] REG_GENERAL_ONE = 3'h1;
    localparam logic [2:0] REG_GENERAL_TWO = 3'h2;
    localparam logic [2:0] REG_SOURCE      = 3'h3;
    localparam logic [2:0] REG_FLOW        = 3'h4;
    localparam logic [2:0] REG_STROBE      = 3'h5;
    localparam logic [7:0] GENERAL_ONE_RESET = 8'h00;
    localparam logic [7:0] GENERAL_TWO_RESET = 8'hff;
    localparam logic [7:0] SOURCE_RESET      = 8'hff;
    localparam logic [7:0] FLOW_RESET        = 8'hff;
    localparam logic [7:0] STROBE_RESET      = 8'h0f;
    // ==========
    // field positions
    localparam int PS_LO_BIT      = 1;
    localparam int PS_HI_BIT      = 2;
    localparam int HW_ENABLE_N    = 5;
    localparam int ECHO_FORCE_N   = 3;
    localparam int D_LOCAL_N      = 0;
    localparam int SLOT_EN_LO     = 2;
    localparam int B1_SLOT_N      = 5;
    localparam int B2_SLOT_N      = 6;
    localparam int D_TAP_N        = 7;
    localparam int B1_SRC_LO      = 0;
    localparam int B2_SRC_LO      = 2;
    localparam int STROBE_POL_BIT = 3;
    localparam logic [2:0] ENV_B1 = 3'h7;
    localparam logic [2:0] ENV_B2 = 3'h6;
    localparam logic [2:0] ENV_D  = 3'h5;
    // ==========
    // frame layout, one slot per bit
    localparam logic [4:0] B1_FIRST = 5'h00;
    localparam logic [4:0] B1_LAST  = 5'h07;
    localparam logic [4:0] B2_FIRST = 5'h08;
    localparam logic [4:0] B2_LAST  = 5'h0f;
    localparam logic [4:0] D_FIRST  = 5'h10;
    localparam logic [4:0] D_LAST   = 5'h11;
    localparam logic [4:0] SLOT_END = 5'h1f;
    // ==========
    // controller APB map
    localparam logic [11:0] APB_COMMAND  = 12'h000;
    localparam logic [11:0] APB_STATUS   = 12'h004;
    localparam logic [11:0] APB_TAKEOVER = 12'h008;
    localparam int CMD_WRITE_BIT = 12;
    localparam int CMD_INDEX_LO  = 8;

    function automatic logic in_slot(input logic [4:0] s, lo, hi);
        in_slot = (s >= lo) && (s <= hi);
    endfunction : in_slot
endpackage : router_pkg

// ==== rtl/highway_if.sv ====
// highway and register-access signals between device end and controller end
`timescale 1ns/100ps
interface highway_if;
    // register access handshake, controller to device
    logic       reg_req_toggle;
    logic       reg_write;
    logic [2:0] reg_index;
    logic [7:0] reg_wdata;
    logic       reg_ack_toggle;
    logic [7:0] reg_rdata;
    // tdm highway
    logic       highway_data_out;
    logic       highway_data_out_oe;
    logic       highway_clock;
    logic       frame_strobe;
    logic       highway_data_in;
    // pulled-up data wire
    logic       highway_data_line;
    assign highway_data_line = highway_data_out_oe ? highway_data_out : 1'b1;

    modport device (
        input  reg_req_toggle, reg_write, reg_index, reg_wdata, highway_data_in,
        output reg_ack_toggle, reg_rdata, highway_data_out, highway_data_out_oe,
        output highway_clock, frame_strobe
    );
    modport controller (
        output reg_req_toggle, reg_write, reg_index, reg_wdata, highway_data_in,
        input  reg_ack_toggle, reg_rdata, highway_data_line, highway_clock,
        input  frame_strobe
    );
endinterface : highway_if

// ==== rtl/frame_slot_counter.sv ====
// bit phase and slot position of the 32-slot frame
`timescale 1ns/100ps
module frame_slot_counter
    import router_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // position
    output logic            phase_q,
    output logic [4:0]      slot_q,
    output logic            bit_end
);
    // each slot lasts two link clocks
    assign bit_end = phase_q;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            phase_q <= 1'b0;
            slot_q  <= 5'h00;
        end
        else
        begin
            phase_q <= ~phase_q;
            if (bit_end)
                slot_q <= (slot_q == SLOT_END) ? 5'h00 : slot_q + 5'h01;
        end
    end
endmodule : frame_slot_counter

// ==== rtl/router_device.sv ====
// device end: channel routing between line, subscriber and tdm highway
`timescale 1ns/100ps
module router_device
    import router_pkg::*;
(
    // link clock and reset
    input  wire logic       link_clock,
    input  wire logic       reset,
    // highway side
    highway_if.device       hw,
    // line interface, bit-serial: down bit aligned to slot_index, up bit two slots behind
    input  wire logic       line_down_bit,
    output logic            line_up_bit,
    // subscriber interface
    input  wire logic       sub_up_bit,
    output logic            sub_down_bit,
    output logic            sub_echo_bit,
    // frame timing for the user side
    output logic            bit_strobe,
    output logic [4:0]      slot_index,
    // power status
    input  wire logic [1:0] power_status_in,
    output logic [1:0]      power_status_outputs
);
    // ==========
    // registers
    logic [7:0] general_config_one_q, general_config_two_q, upstream_source_select_q;
    logic [7:0] highway_flow_enable_q, strobe_timing_config_q, rdata_q;
    logic       req_s1_q, req_s2_q, ack_q, phase_q, bit_end;
    logic [4:0] slot_q, hw_slot_q;
    logic       hw_data_q, hw_oe_q, hw_clk_q, strobe_q;
    logic       sub_prev_q, up_q, echo_q, down_q;
    logic [1:0] ps_q;

    frame_slot_counter slots (
        .clock   (link_clock),
        .reset   (reset),
        .phase_q (phase_q),
        .slot_q  (slot_q),
        .bit_end (bit_end)
    );

    // ==========
    // decode
    wire highway_enable_n  = general_config_two_q[HW_ENABLE_N];
    wire echo_force_n      = general_config_two_q[ECHO_FORCE_N];
    wire upstream_d_local_n = highway_flow_enable_q[D_LOCAL_N];
    wire downstream_d_tap_n = highway_flow_enable_q[D_TAP_N];
    wire highway_on        = ~highway_enable_n;
    wire slots_on = highway_on & ~(&highway_flow_enable_q[7:SLOT_EN_LO]);
    wire in_b1 = in_slot(slot_q, B1_FIRST, B1_LAST);
    wire in_b2 = in_slot(slot_q, B2_FIRST, B2_LAST);
    wire in_d  = in_slot(slot_q, D_FIRST, D_LAST);
    wire up_b1 = in_slot(hw_slot_q, B1_FIRST, B1_LAST);
    wire up_b2 = in_slot(hw_slot_q, B2_FIRST, B2_LAST);
    wire up_d  = in_slot(hw_slot_q, D_FIRST, D_LAST);
    // slot gating: only enabled slots drive the highway
    wire slot_driven = slots_on & ((in_b1 & ~highway_flow_enable_q[B1_SLOT_N])
                                 | (in_b2 & ~highway_flow_enable_q[B2_SLOT_N])
                                 | (in_d  & ~downstream_d_tap_n));
    // envelope from low field, polarity from bit 3
    wire [2:0] envelope = strobe_timing_config_q[2:0];
    wire in_envelope = (envelope == ENV_B1) ? in_b1 :
                       (envelope == ENV_B2) ? in_b2 :
                       (envelope == ENV_D)  ? in_d  : (slot_q == SLOT_END);
    wire strobe_level = strobe_timing_config_q[STROBE_POL_BIT] ? in_envelope
                                                               : ~in_envelope;
    wire strobe_idle = ~strobe_timing_config_q[STROBE_POL_BIT];

    // ==========
    // upstream selection
    // field 11 subscriber, bit 1 clear highway, 10 idle ones
    function automatic logic pick_b(input logic [1:0] field, input logic sub, input logic hwbit);
        if (!field[1])
            pick_b = hwbit;
        else if (!field[0])
            pick_b = 1'b1;
        else
            pick_b = sub;
    endfunction : pick_b

    wire b1_up = pick_b(upstream_source_select_q[B1_SRC_LO +: 2],
                        sub_prev_q, hw.highway_data_in);
    wire b2_up = pick_b(upstream_source_select_q[B2_SRC_LO +: 2],
                        sub_prev_q, hw.highway_data_in);
    // during takeover the line sees ones so a cut terminal frame aborts
    wire d_up = (!echo_force_n && upstream_d_local_n) ? 1'b1 :
                (!upstream_d_local_n) ? hw.highway_data_in : sub_prev_q;
    wire up_next = up_b1 ? b1_up : up_b2 ? b2_up : up_d ? d_up : 1'b1;
    wire echo_next = !up_d ? 1'b1 : !echo_force_n ? ~sub_prev_q : d_up;

    // ==========
    // register access from the controller
    wire req_seen = req_s2_q ^ ack_q;
    wire [7:0] status_word = {6'h00, slots_on, highway_on};
    // indexes 0..5 sit in order, one byte each
    wire [47:0] reg_file = {strobe_timing_config_q, highway_flow_enable_q,
                            upstream_source_select_q, general_config_two_q,
                            general_config_one_q, status_word};
    wire [7:0] read_word = (hw.reg_index > REG_STROBE) ? 8'h00
                                                       : reg_file[{hw.reg_index, 3'b000} +: 8];
    wire wr = req_seen & hw.reg_write;

    always_ff @(posedge link_clock or posedge reset)
    begin
        if (reset)
        begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            ack_q    <= 1'b0;
            rdata_q  <= 8'h00;
        end
        else
        begin
            req_s1_q <= hw.reg_req_toggle;
            req_s2_q <= req_s1_q;
            if (req_seen)
            begin
                ack_q   <= ~ack_q;
                rdata_q <= hw.reg_write ? hw.reg_wdata : read_word;
            end
        end
    end

    always_ff @(posedge link_clock or posedge reset)
    begin
        if (reset)
        begin
            general_config_one_q     <= GENERAL_ONE_RESET;
            general_config_two_q     <= GENERAL_TWO_RESET;
            upstream_source_select_q <= SOURCE_RESET;
            highway_flow_enable_q    <= FLOW_RESET;
            strobe_timing_config_q   <= STROBE_RESET;
        end
        else if (wr)
        begin
            case (hw.reg_index)
                REG_GENERAL_ONE: general_config_one_q <= hw.reg_wdata;
                REG_GENERAL_TWO: general_config_two_q <= hw.reg_wdata;
                REG_SOURCE:      upstream_source_select_q <= hw.reg_wdata;
                REG_FLOW:        highway_flow_enable_q <= hw.reg_wdata;
                REG_STROBE:      strobe_timing_config_q <= hw.reg_wdata;
                default:         ;
            endcase
        end
    end

    // ==========
    // highway timing: highway slot n carries line slot n one bit later
    always_ff @(posedge link_clock or posedge reset)
    begin
        if (reset)
        begin
            hw_slot_q <= 5'h00;
            hw_data_q <= 1'b1;
            hw_oe_q   <= 1'b0;
            hw_clk_q  <= 1'b0;
            strobe_q  <= 1'b0;
        end
        else
        begin
            hw_clk_q <= slots_on & ~phase_q;
            if (bit_end)
            begin
                hw_slot_q <= slot_q;
                hw_data_q <= line_down_bit;
                hw_oe_q   <= slot_driven;
                strobe_q  <= slots_on ? strobe_level : strobe_idle;
            end
        end
    end

    // ==========
    // line and subscriber bits, updated once per slot
    always_ff @(posedge link_clock or posedge reset)
    begin
        if (reset)
        begin
            sub_prev_q <= 1'b1;
            up_q       <= 1'b1;
            echo_q     <= 1'b1;
            down_q     <= 1'b1;
            ps_q       <= 2'b00;
        end
        else
        begin
            // pins shared with highway: status from config
            ps_q <= highway_on ? general_config_one_q[PS_HI_BIT:PS_LO_BIT]
                               : power_status_in;
            if (bit_end)
            begin
                sub_prev_q <= sub_up_bit;
                up_q       <= up_next;
                echo_q     <= echo_next;
                down_q     <= line_down_bit;
            end
        end
    end

    // ==========
    // outputs
    assign hw.reg_ack_toggle      = ack_q;
    assign hw.reg_rdata           = rdata_q;
    assign hw.highway_data_out    = hw_data_q;
    assign hw.highway_data_out_oe = hw_oe_q & highway_on;
    assign hw.highway_clock       = hw_clk_q;
    assign hw.frame_strobe        = strobe_q;
    assign line_up_bit            = up_q;
    assign sub_down_bit           = down_q;
    assign sub_echo_bit           = echo_q;
    assign bit_strobe             = bit_end;
    assign slot_index             = slot_q;
    assign power_status_outputs   = ps_q;
endmodule : router_device

// ==== rtl/highway_controller.sv ====
// controller end: apb register window, d-channel takeover and highway tap
`timescale 1ns/100ps
module highway_controller
    import router_pkg::*;
#(
    parameter int WAIT_CYCLES = TAKEOVER_WAIT_CYCLES
)
(
    // system clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // highway, link clock domain
    input  wire logic        link_clock,
    highway_if.controller    hw,
    input  wire logic        tx_bit,
    output logic             rx_bit,
    output logic             rx_valid,
    output logic             rx_frame
);
    typedef enum logic [6:0] {
        ST_IDLE   = 7'b000_0001,
        ST_ECHO   = 7'b000_0010,
        ST_WAIT   = 7'b000_0100,
        ST_LOCAL  = 7'b000_1000,
        ST_OWNED  = 7'b001_0000,
        ST_DROP   = 7'b010_0000,
        ST_RESTORE = 7'b100_0000
    } take_t;

    take_t       state_q, state_d;
    logic        req_q, write_q, ack_s1_q, ack_s2_q;
    logic [2:0]  index_q;
    logic [7:0]  wdata_q, rdata_q, gen_two_q, flow_q;
    logic [31:0] wait_q, prdata_q;

    // ==========
    // apb decode; pready is always high, one access cycle
    wire busy    = req_q ^ ack_s2_q;
    wire acc     = psel & penable;
    wire hit_cmd = paddr == APB_COMMAND;
    wire hit_sta = paddr == APB_STATUS;
    wire hit_tko = paddr == APB_TAKEOVER;
    wire mapped  = hit_cmd | hit_sta | hit_tko;
    wire sw_free = ~busy & (state_q == ST_IDLE);
    wire sw_cmd  = acc & pwrite & hit_cmd & sw_free;
    wire bad_cmd = pwrite & hit_cmd & ~sw_free;
    wire tko_wr  = acc & pwrite & hit_tko;
    wire owned   = state_q == ST_OWNED;
    wire [31:0] read_word = hit_sta ? {16'h0000, rdata_q, 6'h00, owned, busy} :
                            hit_tko ? {31'h0000_0000, owned} : 32'h0000_0000;

    // ==========
    // takeover sequencer launches register writes itself
    wire fsm_go = ~busy & (state_q == ST_ECHO | state_q == ST_LOCAL |
                           state_q == ST_DROP | state_q == ST_RESTORE);
    wire [2:0] fsm_index = (state_q == ST_ECHO | state_q == ST_RESTORE)
                           ? REG_GENERAL_TWO : REG_FLOW;
    wire [7:0] echo_clr  = gen_two_q & ~(8'h01 << ECHO_FORCE_N);
    wire [7:0] echo_set  = gen_two_q | (8'h01 << ECHO_FORCE_N);
    wire [7:0] local_on  = flow_q & ~(8'h01 << D_LOCAL_N);
    wire [7:0] local_off = flow_q | (8'h01 << D_LOCAL_N);
    wire [7:0] fsm_data  = (state_q == ST_ECHO)  ? echo_clr :
                           (state_q == ST_LOCAL) ? local_on :
                           (state_q == ST_DROP)  ? local_off : echo_set;
    wire       launch    = fsm_go | sw_cmd;
    wire       l_write   = fsm_go ? 1'b1 : pwdata[CMD_WRITE_BIT];
    wire [2:0] l_index   = fsm_go ? fsm_index : pwdata[CMD_INDEX_LO +: 3];
    wire [7:0] l_data    = fsm_go ? fsm_data : pwdata[7:0];

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:    if (tko_wr && pwdata[0] && !busy) state_d = ST_ECHO;
            ST_ECHO:    if (!busy) state_d = ST_WAIT;
            ST_WAIT:    if (!busy && wait_q == 32'h0000_0000) state_d = ST_LOCAL;
            ST_LOCAL:   if (!busy) state_d = ST_OWNED;
            ST_OWNED:   if (tko_wr && !pwdata[0]) state_d = ST_DROP;
            ST_DROP:    if (!busy) state_d = ST_RESTORE;
            ST_RESTORE: if (!busy) state_d = ST_IDLE;
            default:    state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_q  <= ST_IDLE;
            wait_q   <= 32'h0000_0000;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            rdata_q  <= 8'h00;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            state_q  <= state_d;
            ack_s1_q <= hw.reg_ack_toggle;
            ack_s2_q <= ack_s1_q;
            if (!busy)
                rdata_q <= hw.reg_rdata;
            if (psel && !penable)
                prdata_q <= read_word;
            // the wait starts only once the echo write has landed
            if (state_q == ST_ECHO)
                wait_q <= 32'(WAIT_CYCLES);
            else if (state_q == ST_WAIT && !busy && wait_q != 32'h0000_0000)
                wait_q <= wait_q - 32'h0000_0001;
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            req_q     <= 1'b0;
            write_q   <= 1'b0;
            index_q   <= REG_STATUS;
            wdata_q   <= 8'h00;
            gen_two_q <= GENERAL_TWO_RESET;
            flow_q    <= FLOW_RESET;
        end
        else if (launch)
        begin
            req_q   <= ~req_q;
            write_q <= l_write;
            index_q <= l_index;
            wdata_q <= l_data;
            if (l_write && l_index == REG_GENERAL_TWO)
                gen_two_q <= l_data;
            if (l_write && l_index == REG_FLOW)
                flow_q <= l_data;
        end
    end

    // ==========
    // highway tap, link domain like highway_clock
    logic rx_bit_q, rx_valid_q, rx_frame_q, tx_q;

    always_ff @(posedge link_clock or posedge reset)
    begin
        if (reset)
        begin
            rx_bit_q   <= 1'b1;
            rx_valid_q <= 1'b0;
            rx_frame_q <= 1'b0;
            tx_q       <= 1'b1;
        end
        else
        begin
            rx_valid_q <= hw.highway_clock;
            if (hw.highway_clock)
            begin
                rx_bit_q   <= hw.highway_data_line;
                rx_frame_q <= hw.frame_strobe;
                tx_q       <= tx_bit;
            end
        end
    end

    assign hw.reg_req_toggle  = req_q;
    assign hw.reg_write       = write_q;
    assign hw.reg_index       = index_q;
    assign hw.reg_wdata       = wdata_q;
    assign hw.highway_data_in = tx_q;
    assign rx_bit             = rx_bit_q;
    assign rx_valid           = rx_valid_q;
    assign rx_frame           = rx_frame_q;
    assign prdata             = prdata_q;
    assign pready             = 1'b1;
    assign pslverr            = acc & (~mapped | bad_cmd);
endmodule : highway_controller

// ==== tb/router_monitor.sv ====
// highway handshake and slot timing assertions
`timescale 1ns/100ps
module router_monitor (
    // link clock and reset
    input wire logic       link_clock,
    input wire logic       reset,
    // register handshake
    input wire logic       reg_req_toggle,
    input wire logic       reg_ack_toggle,
    input wire logic [2:0] reg_index,
    input wire logic [7:0] reg_wdata,
    // highway
    input wire logic       highway_clock,
    input wire logic       frame_strobe,
    input wire logic       highway_data_out,
    input wire logic       highway_data_out_oe
);
    default clocking cb @(posedge link_clock); endclocking
    default disable iff (reset);
    // ==========
    // slot timing
    property p_pulse; highway_clock |=> !highway_clock; endproperty
    a_pulse: assert property (p_pulse) else $error("clock high twice");
    property p_idle_fs; !highway_clock [*2] |=> !frame_strobe || highway_clock; endproperty
    a_idle_fs: assert property (p_idle_fs) else $error("strobe while idle");
    property p_idle_oe; !highway_clock [*2] |=> !highway_data_out_oe || highway_clock; endproperty
    a_idle_oe: assert property (p_idle_oe) else $error("drive while idle");
    property p_hold; highway_clock |-> $stable(highway_data_out) && $stable(frame_strobe); endproperty
    a_hold: assert property (p_hold) else $error("change inside slot");
    // a strobe cut short by the clock starting mid-envelope is not a full pulse
    property p_b1; $rose(frame_strobe) && $past(highway_clock, 3) |->
        ##15 (frame_strobe || !highway_clock) ##1 !frame_strobe;
    endproperty
    a_b1: assert property (p_b1) else $error("strobe not eight slots");
    // ==========
    // register handshake
    property p_ack; $changed(reg_req_toggle) |-> ##[1:8] $changed(reg_ack_toggle); endproperty
    a_ack: assert property (p_ack) else $error("request not answered");
    property p_open; $changed(reg_ack_toggle) |-> $past(reg_req_toggle) != $past(reg_ack_toggle);
    endproperty
    a_open: assert property (p_open) else $error("answer without request");
    property p_req; (reg_req_toggle != reg_ack_toggle) [*2] |-> $stable({reg_index, reg_wdata});
    endproperty
    a_req: assert property (p_req) else $error("request changed while open");
endmodule : router_monitor

// ==== tb/isdn_channel_flow_router_tb_top.sv ====
// bench: apb drives both router ends over the highway
`timescale 1ns/100ps
module isdn_channel_flow_router_tb_top;
    import router_pkg::*;
    logic        clock = 1'b0, link_clock = 1'b0, reset = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr, tx_bit, live, tk;
    logic        line_down_bit, line_up_bit, sub_up_bit, bit_strobe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [4:0]  slot_index, k;
    logic [1:0]  power_status_in, power_status_outputs;
    logic [15:0] lfsr_q = 16'h4e4c;
    logic [7:0]  sh [0:7];
    logic        hist [0:31];
    int          err_total, n_tests, run, best;
    always #10 clock = ~clock;
    always #3 link_clock = ~link_clock;
    highway_if highway_if_inst ();
    router_device router_device_inst (.link_clock, .reset, .hw(highway_if_inst), .line_down_bit,
        .line_up_bit, .sub_up_bit, .sub_down_bit(), .sub_echo_bit(), .bit_strobe, .slot_index,
        .power_status_in, .power_status_outputs);
    highway_controller #(.WAIT_CYCLES(200)) highway_controller_inst (.clock, .reset, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_clock,
        .hw(highway_if_inst), .tx_bit, .rx_bit(), .rx_valid(), .rx_frame());
    router_monitor router_monitor_inst (.link_clock, .reset,
        .reg_req_toggle(highway_if_inst.reg_req_toggle),
        .reg_ack_toggle(highway_if_inst.reg_ack_toggle),
        .reg_index(highway_if_inst.reg_index), .reg_wdata(highway_if_inst.reg_wdata),
        .highway_clock(highway_if_inst.highway_clock),
        .frame_strobe(highway_if_inst.frame_strobe),
        .highway_data_out(highway_if_inst.highway_data_out),
        .highway_data_out_oe(highway_if_inst.highway_data_out_oe));
    // ==========
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // tx_bit stays low: highway bits read 0
    function automatic logic exp_up(input logic [4:0] s, input logic sb);
        logic [1:0] f;
        f = (s <= B1_LAST) ? sh[3][1:0] : sh[3][3:2];
        if (s >= D_FIRST)
            return !sh[4][0] ? 1'b0 : (!sh[2][3] ? 1'b1 : sb);
        return (f == 2'b11) ? sb : f[1];
    endfunction : exp_up
    task automatic chk(input string name, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("FAIL %s expected %h seen %h", name, exp, seen);
            err_total++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic dev(input logic w, input logic [2:0] i, input logic [7:0] d,
                       output logic [7:0] r);
        logic [31:0] s;
        logic        e;
        apb(1'b1, APB_COMMAND, {19'h0_0000, w, 1'b0, i, d}, s, e);
        s = 32'h0000_0001;
        while (s[0] !== 1'b0) apb(1'b0, APB_STATUS, 32'h0000_0000, s, e);
        r = s[15:8];
        if (w) sh[i] = d;
    endtask : dev
    // line checks pause while a new setting settles
    task automatic cfg(input logic [2:0] i, input logic [7:0] d);
        logic [7:0] r;
        live = 1'b0;
        dev(1'b1, i, d, r);
        repeat (50) @(posedge clock);
        live = 1'b1;
    endtask : cfg
    // ten whole frames: counts free of start phase
    task automatic meas();
        int         hc, oe;
        logic [7:0] r;
        logic       on;
        hc = 0;
        oe = 0;
        on = !sh[2][5] && sh[4][7:2] != 6'h3f;
        repeat (640) @(negedge link_clock)
        begin
            hc += highway_if_inst.highway_clock;
            oe += highway_if_inst.highway_data_out_oe;
        end
        chk("clock cycles", hc, on ? 320 : 0);
        chk("drive cycles", oe, on ? 40 * !sh[4][7] + 160 * (!sh[4][5] + !sh[4][6]) : 0);
        dev(1'b0, REG_STATUS, 8'h00, r);
        chk("status", r, {6'h00, on, !sh[2][5]});
    endtask : meas
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop
    // ==========
    // line check, random pins
    always @(posedge link_clock)
        if (bit_strobe === 1'b1)
        begin
            k = slot_index - 5'h02;
            hist[slot_index] <= sub_up_bit;
            if (live && k <= D_LAST)
                chk("line upstream", line_up_bit, exp_up(k, hist[k]));
            if (tk && k >= D_FIRST && k <= D_LAST)
                run = line_up_bit ? run + 1 : 0;
            best = run > best ? run : best;
            lfsr_q        <= lfsr(lfsr_q);
            sub_up_bit    <= lfsr_q[0];
            line_down_bit <= lfsr_q[5];
        end
    initial
    begin
        #500000;
        err_total++;
        report_and_stop();
    end
    initial
    begin
        logic [31:0] r;
        logic        e;
        {psel, penable, pwrite, paddr, pwdata, tx_bit, sub_up_bit, line_down_bit, live, tk} = '0;
        power_status_in = 2'b01;
        foreach (sh[i]) sh[i] = 8'hff;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        for (int i = 1; i < 6; i++)
        begin
            dev(1'b0, 3'(i), 8'h00, r[7:0]);
            chk("reset value", r[7:0], i == 1 ? 8'h00 : (i == 5 ? 8'h0f : 8'hff));
        end
        apb(1'b0, 12'h00c, 32'h0000_0000, r, e);
        chk("unmapped error", e, 1'b1);
        cfg(REG_FLOW, 8'h1f);
        meas();
        cfg(REG_GENERAL_ONE, 8'h04);
        cfg(REG_GENERAL_TWO, 8'hdf);
        chk("power status", power_status_outputs, 2'b10);
        cfg(REG_FLOW, 8'hff);
        meas();
        for (int j = 0; j < 8; j++)
        begin
            cfg(REG_SOURCE, {4'hf, lfsr_q[3:0]});
            cfg(REG_FLOW, j == 0 ? 8'h7f : {lfsr_q[15:10], 2'b11});
            meas();
        end
        live = 1'b0;
        tk = 1'b1;
        apb(1'b1, APB_TAKEOVER, 32'h0000_0001, r, e);
        r = 32'h0000_0000;
        while (r[0] !== 1'b1) apb(1'b0, APB_TAKEOVER, 32'h0000_0000, r, e);
        tk = 1'b0;
        chk("ones before local d", best >= 7, 1'b1);
        sh[2][3] = 1'b0;
        sh[4][0] = 1'b0;
        repeat (50) @(posedge clock);
        live = 1'b1;
        repeat (200) @(posedge clock);
        live = 1'b0;
        apb(1'b1, APB_TAKEOVER, 32'h0000_0000, r, e);
        sh[2][3] = 1'b1;
        sh[4][0] = 1'b1;
        repeat (50) @(posedge clock);
        live = 1'b1;
        meas();
        report_and_stop();
    end
endmodule : isdn_channel_flow_router_tb_top
